// File: bench/host_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
  input wire logic aclk,
  output logic [7:0] host_ev,
  output logic host_oe_n,
  output logic host_we_n
);
  // Strobes idle high: no host bus cycle outside a transfer
  initial begin
    host_ev = 8'h00;
    host_oe_n = 1'b1;
    host_we_n = 1'b1;
  end
  task automatic pulse(input int i);
    @(posedge aclk);
    host_ev[i] <= 1'b1;
    @(posedge aclk);
    host_ev[i] <= 1'b0;
  endtask
  // Read strobe held low long enough for the handshake wait count
  task automatic read_hold(input int n);
    @(posedge aclk);
    host_oe_n <= 1'b0;
    repeat (n) @(posedge aclk);
    host_oe_n <= 1'b1;
  endtask
  // Held low four cycles so the two-stage synchroniser sees it
  task automatic strobe(input logic wr);
    @(posedge aclk);
    if (wr) begin
      host_we_n <= 1'b0;
    end else begin
      host_oe_n <= 1'b0;
    end
    repeat (4) @(posedge aclk);
    host_we_n <= 1'b1;
    host_oe_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// File: bench/host_port_flags_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); \
  end \
end
module host_port_flags_tb_top;
  import host_port_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] hev;
  logic [8:0] cev;
  logic hoe_n, hwe_n, as_q, stby_n;
  logic rp_o, rp_oe, wp_o, wp_oe, rirq, wirq;
  int n_errors = 0;
  int cmp_count = 0;
  host_bus_model i_host_bus_model (.aclk(aclk), .host_ev(hev),
    .host_oe_n(hoe_n), .host_we_n(hwe_n));
  host_port_flags i_host_port_flags (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .host_rd_read_buf_ptr(hev[0]),
    .host_wr_write_buf_ptr(hev[1]), .host_rd_read_lo(hev[2]),
    .host_wr_write_lo(hev[3]), .host_rd_read_pair(hev[4]),
    .host_wr_write_pair(hev[5]), .host_rd_query(hev[6]),
    .host_wr_query(hev[7]), .cpu_wr_read_lo(cev[0]),
    .cpu_rd_read_lo(cev[1]), .cpu_rd_write_lo(cev[2]),
    .cpu_wr_write_lo(cev[3]), .tu_read_pair_loaded(cev[4]),
    .tu_write_pair_drained(cev[5]), .tu_query_loaded(cev[6]),
    .chan_a_boundary(cev[7]), .chan_b_boundary(cev[8]),
    .addr_strobe_out(as_q), .host_oe_n(hoe_n), .host_we_n(hwe_n),
    .hw_standby_n(stby_n), .ready_pin_o(rp_o), .ready_pin_oe(rp_oe),
    .wait_pin_o(wp_o), .wait_pin_oe(wp_oe), .read_done_irq(rirq),
    .write_done_irq(wirq));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    `CHK(bresp, RESP_OKAY)
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e,
                     input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    `CHK(rdata, {24'h000000, e})
    `CHK(rresp, er)
  endtask
  task automatic ev(input int i);
    @(posedge aclk);
    cev[i] <= 1'b1;
    @(posedge aclk);
    cev[i] <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic hp(input int i);
    i_host_bus_model.pulse(i);
    repeat (3) @(posedge aclk);
  endtask
  task automatic s_regs();
    chk(ADDR_HOST_PORT_CONTROL_STATUS, 8'h00, RESP_OKAY);
    chk(ADDR_SYSTEM_CONTROL, SYSTEM_CONTROL_RESET, RESP_OKAY);
    chk(8'h0C, 8'h00, RESP_SLVERR);
    axw(ADDR_SYSTEM_CONTROL, 8'h03);
    chk(ADDR_SYSTEM_CONTROL, 8'h0B, RESP_OKAY);
  endtask
  task automatic s_direct();
    axw(ADDR_MODE, 8'h02);
    axw(ADDR_HOST_PORT_CONTROL_STATUS, 8'h13);
    repeat (3) @(posedge aclk);
    `CHK({rp_oe, rp_o}, 2'b10)
    hp(2);
    chk(ADDR_HOST_PORT_CONTROL_STATUS, 8'h17, RESP_OKAY);
    `CHK(rirq, 1'b1)
    `CHK(rp_oe, 1'b0)
    ev(0);
    chk(ADDR_HOST_PORT_CONTROL_STATUS, 8'h13, RESP_OKAY);
    `CHK({rp_oe, rirq}, 2'b10)
    axw(ADDR_HOST_PORT_CONTROL_STATUS, 8'h33);
    hp(3);
    chk(ADDR_HOST_PORT_CONTROL_STATUS, 8'h3B, RESP_OKAY);
    `CHK(wirq, 1'b1)
    ev(2);
    chk(ADDR_HOST_PORT_CONTROL_STATUS, 8'h33, RESP_OKAY);
  endtask
  task automatic s_bound();
    axw(ADDR_MODE, 8'h00);
    axw(ADDR_HOST_PORT_CONTROL_STATUS, 8'h00);
    ev(7);
    ev(8);
    `CHK(rirq, 1'b0)
    chk(ADDR_HOST_PORT_CONTROL_STATUS, 8'h0C, RESP_OKAY);
    axw(ADDR_HOST_PORT_CONTROL_STATUS, 8'h0C);
    axw(ADDR_HOST_PORT_CONTROL_STATUS, 8'h00);
    chk(ADDR_HOST_PORT_CONTROL_STATUS, 8'h0C, RESP_OKAY);
    axw(ADDR_HOST_PORT_CONTROL_STATUS, 8'h00);
    chk(ADDR_HOST_PORT_CONTROL_STATUS, 8'h00, RESP_OKAY);
    hp(7);
    chk(ADDR_HOST_PORT_CONTROL_STATUS, 8'h80, RESP_OKAY);
    ev(6);
    chk(ADDR_HOST_PORT_CONTROL_STATUS, 8'h00, RESP_OKAY);
  endtask
  task automatic s_hs();
    axw(ADDR_MODE, 8'h01);
    i_host_bus_model.strobe(1'b0);
    repeat (4) @(posedge aclk);
    chk(ADDR_HOST_PORT_CONTROL_STATUS, 8'h04, RESP_OKAY);
    i_host_bus_model.strobe(1'b1);
    repeat (4) @(posedge aclk);
    chk(ADDR_HOST_PORT_CONTROL_STATUS, 8'h0C, RESP_OKAY);
    ev(1);
    ev(3);
    chk(ADDR_HOST_PORT_CONTROL_STATUS, 8'h00, RESP_OKAY);
    axw(ADDR_HOST_PORT_CONTROL_STATUS, 8'h40);
    ev(0);
    `CHK({wp_oe, wp_o}, 2'b10)
    i_host_bus_model.read_hold(12);
    repeat (4) @(posedge aclk);
    `CHK({wp_oe, wp_o}, 2'b11)
  endtask
  task automatic s_exp();
    axw(ADDR_MODE, 8'h04);
    repeat (3) @(posedge aclk);
    `CHK({wp_oe, wp_o}, 2'b11)
    @(posedge aclk);
    as_q <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK({rp_oe, rp_o}, 2'b11)
    as_q <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK({rp_oe, rp_o}, 2'b10)
    axw(ADDR_HOST_PORT_CONTROL_STATUS, 8'h40);
    hp(4);
    `CHK({wp_oe, wp_o}, 2'b10)
    ev(4);
    `CHK(wp_o, 1'b1)
  endtask
  task automatic s_standby();
    @(posedge aclk);
    stby_n <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(ADDR_SYSTEM_CONTROL, SYSTEM_CONTROL_RESET, RESP_OKAY);
    stby_n <= 1'b1;
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    complete_run();
  end
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    cev = 9'h000;
    as_q = 1'b0;
    stby_n = 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    s_regs();
    s_direct();
    s_bound();
    s_hs();
    s_exp();
    s_standby();
    complete_run();
  end
endmodule
`default_nettype wire

// File: include/host_port_pkg.sv
package host_port_pkg;
  localparam logic [7:0] ADDR_HOST_PORT_CONTROL_STATUS = 8'h00;
  localparam logic [7:0] ADDR_SYSTEM_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  localparam int unsigned BIT_QUERY = 7;
  localparam int unsigned BIT_WAIT_EN = 6;
  localparam int unsigned BIT_WR_ACK = 5;
  localparam int unsigned BIT_RD_ACK = 4;
  localparam int unsigned BIT_WR_DONE = 3;
  localparam int unsigned BIT_RD_DONE = 2;
  localparam int unsigned BIT_WR_IRQ_EN = 1;
  localparam int unsigned BIT_RD_IRQ_EN = 0;
  localparam logic [7:0] HOST_PORT_CONTROL_STATUS_WR_MASK = 8'h73;
  localparam int unsigned BIT_SLAVE_EN = 1;
  localparam logic [7:0] SYSTEM_CONTROL_RESET = 8'h09;
  localparam logic [7:0] SYSTEM_CONTROL_RO_MASK = 8'h08;
  localparam int unsigned BIT_HS_SEL = 0;
  localparam int unsigned BIT_DIRECT = 1;
  localparam int unsigned BIT_EXPANDED = 2;
  localparam logic [7:0] MODE_WR_MASK = 8'h07;
  localparam logic [3:0] HS_WAIT_CLKS = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    XM_IO = 4'b0001,
    XM_BOUND = 4'b0010,
    XM_DIRECT = 4'b0100,
    XM_HS = 4'b1000
  } xfer_mode_e;
endpackage

// File: rtl/host_port_flags.sv
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module host_port_flags (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic host_rd_read_buf_ptr,
  input wire logic host_wr_write_buf_ptr,
  input wire logic host_rd_read_lo,
  input wire logic host_wr_write_lo,
  input wire logic host_rd_read_pair,
  input wire logic host_wr_write_pair,
  input wire logic host_rd_query,
  input wire logic host_wr_query,
  input wire logic cpu_wr_read_lo,
  input wire logic cpu_rd_read_lo,
  input wire logic cpu_rd_write_lo,
  input wire logic cpu_wr_write_lo,
  input wire logic tu_read_pair_loaded,
  input wire logic tu_write_pair_drained,
  input wire logic tu_query_loaded,
  input wire logic chan_a_boundary,
  input wire logic chan_b_boundary,
  input wire logic addr_strobe_out,
  input wire logic host_oe_n,
  input wire logic host_we_n,
  input wire logic hw_standby_n,
  output logic ready_pin_o,
  output logic ready_pin_oe,
  output logic wait_pin_o,
  output logic wait_pin_oe,
  output logic read_done_irq,
  output logic write_done_irq
);
  import host_port_pkg::*;

  typedef struct packed {
    logic [7:0] host_port_control_status;
    logic [7:0] system_control;
    logic [7:0] mode;
    logic rd_arm;
    logic wr_arm;
    logic ext_host_ready;
    logic host_wait_req_n;
    logic [3:0] hs_cnt;
    logic [2:0] oe_sync;
    logic [2:0] we_sync;
    logic [1:0] stby_sync;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic ready_pin_o;
    logic ready_pin_oe;
    logic wait_pin_o;
    logic wait_pin_oe;
    logic rd_irq;
    logic wr_irq;
  } state_s;

  state_s q;
  state_s d;
  xfer_mode_e xm;
  logic slave_mode_en;
  logic expanded;
  logic oe_hi;
  logic we_hi;
  logic oe_rise;
  logic we_rise;
  logic wr_fire;
  logic rd_fire;
  logic wr_host_port_control_status;
  logic rd_host_port_control_status;
  logic sw_clr_rd;
  logic sw_clr_wr;
  logic rd_ack;
  logic wr_ack;
  logic hs_wait_cond;

  assign slave_mode_en = q.system_control[BIT_SLAVE_EN];
  assign expanded = q.mode[BIT_EXPANDED];
  assign rd_ack = q.host_port_control_status[BIT_RD_ACK];
  assign wr_ack = q.host_port_control_status[BIT_WR_ACK];
  // Edges come from the second stage and its delayed copy only
  assign oe_hi = q.oe_sync[1];
  assign we_hi = q.we_sync[1];
  assign oe_rise = q.oe_sync[1] & ~q.oe_sync[2];
  assign we_rise = q.we_sync[1] & ~q.we_sync[2];
  assign wr_fire = q.awready & awvalid & wvalid;
  assign rd_fire = q.arready & arvalid;
  assign wr_host_port_control_status = wr_fire & wstrb[0] & (awaddr[7:2] == ADDR_HOST_PORT_CONTROL_STATUS[7:2]);
  assign rd_host_port_control_status = rd_fire & (araddr[7:2] == ADDR_HOST_PORT_CONTROL_STATUS[7:2]);
  // Zero written after reading the flag as one
  assign sw_clr_rd = wr_host_port_control_status & ~wdata[BIT_RD_DONE] & q.rd_arm;
  assign sw_clr_wr = wr_host_port_control_status & ~wdata[BIT_WR_DONE] & q.wr_arm;
  assign hs_wait_cond = (xm == XM_HS) & ~oe_hi & ~q.host_wait_req_n
    & ~cpu_wr_read_lo;

  always_comb begin
    if (!slave_mode_en) begin
      xm = XM_IO;
    end else if (q.mode[BIT_HS_SEL]) begin
      xm = XM_HS;
    end else if (q.mode[BIT_DIRECT]) begin
      xm = XM_DIRECT;
    end else begin
      xm = XM_BOUND;
    end
  end

  always_comb begin
    logic set_rd;
    logic clr_rd;
    logic set_wr;
    logic clr_wr;
    logic rdy_up;
    logic rdy_dn;
    logic wt_up;
    logic wt_dn;
    set_rd = 1'b0;
    clr_rd = sw_clr_rd;
    set_wr = 1'b0;
    clr_wr = sw_clr_wr;
    rdy_up = 1'b0;
    rdy_dn = 1'b0;
    wt_up = tu_query_loaded;
    wt_dn = host_rd_query;
    d = q;
    d.oe_sync = {q.oe_sync[1:0], host_oe_n};
    d.we_sync = {q.we_sync[1:0], host_we_n};
    d.stby_sync = {q.stby_sync[0], hw_standby_n};
    d.hs_cnt = 4'h0;

    unique case (xm)
      XM_BOUND: begin
        set_rd = chan_a_boundary;
        set_wr = chan_b_boundary;
        rdy_up = (rd_ack & host_rd_read_buf_ptr)
          | (wr_ack & host_wr_write_buf_ptr);
        rdy_dn = (rd_ack & sw_clr_rd) | (wr_ack & sw_clr_wr);
        wt_up = wt_up | tu_read_pair_loaded
          | tu_write_pair_drained;
        wt_dn = wt_dn | host_rd_read_pair | host_wr_write_pair;
      end
      XM_DIRECT: begin
        set_rd = host_rd_read_lo;
        set_wr = host_wr_write_lo;
        clr_rd = clr_rd | cpu_wr_read_lo | cpu_rd_read_lo;
        clr_wr = clr_wr | cpu_rd_write_lo | cpu_wr_write_lo;
        rdy_up = (rd_ack & host_rd_read_lo)
          | (wr_ack & host_wr_write_lo);
        rdy_dn = (rd_ack & cpu_wr_read_lo) | (wr_ack & cpu_rd_write_lo);
      end
      XM_HS: begin
        set_rd = oe_rise;
        set_wr = we_rise;
        clr_rd = clr_rd | cpu_wr_read_lo | cpu_rd_read_lo;
        clr_wr = clr_wr | cpu_rd_write_lo | cpu_wr_write_lo;
        rdy_up = cpu_rd_write_lo;
        rdy_dn = oe_hi & ~we_hi;
        wt_up = 1'b0;
        wt_dn = cpu_wr_read_lo;
        if (hs_wait_cond) begin
          d.hs_cnt = q.hs_cnt + 4'h1;
          if (q.hs_cnt == HS_WAIT_CLKS - 4'h1) begin
            wt_up = 1'b1;
            d.hs_cnt = 4'h0;
          end
        end
      end
      XM_IO: begin
        wt_up = 1'b0;
        wt_dn = 1'b0;
      end
    endcase

    // A flag event wins over a clear in the same cycle
    d.host_port_control_status[BIT_RD_DONE] = set_rd | (q.host_port_control_status[BIT_RD_DONE] & ~clr_rd);
    d.host_port_control_status[BIT_WR_DONE] = set_wr | (q.host_port_control_status[BIT_WR_DONE] & ~clr_wr);
    d.host_port_control_status[BIT_QUERY] = host_wr_query
      | (q.host_port_control_status[BIT_QUERY] & ~tu_query_loaded);
    // Handshake low level wins: ready must stay low while it holds
    if (xm == XM_HS) begin
      d.ext_host_ready = ~rdy_dn & (rdy_up | q.ext_host_ready);
    end else begin
      d.ext_host_ready = rdy_up | (q.ext_host_ready & ~rdy_dn);
    end
    d.host_wait_req_n = wt_up | (q.host_wait_req_n & ~wt_dn);

    if (wr_fire) begin
      d.awready = 1'b0;
      d.wready = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      unique case (awaddr[7:2])
        ADDR_HOST_PORT_CONTROL_STATUS[7:2]: begin
          if (wstrb[0]) begin
            d.host_port_control_status = (d.host_port_control_status & ~HOST_PORT_CONTROL_STATUS_WR_MASK)
              | (wdata[7:0] & HOST_PORT_CONTROL_STATUS_WR_MASK);
          end
          d.rd_arm = 1'b0;
          d.wr_arm = 1'b0;
        end
        ADDR_SYSTEM_CONTROL[7:2]: begin
          if (wstrb[0]) begin
            d.system_control = (q.system_control & SYSTEM_CONTROL_RO_MASK)
              | (wdata[7:0] & ~SYSTEM_CONTROL_RO_MASK);
          end
        end
        ADDR_MODE[7:2]: begin
          if (wstrb[0]) begin
            d.mode = wdata[7:0] & MODE_WR_MASK;
          end
        end
        default: d.bresp = RESP_SLVERR;
      endcase
    end else if (!q.bvalid && !q.awready && awvalid && wvalid) begin
      d.awready = 1'b1;
      d.wready = 1'b1;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end

    if (rd_fire) begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      unique case (araddr[7:2])
        ADDR_HOST_PORT_CONTROL_STATUS[7:2]: d.rdata = q.host_port_control_status;
        ADDR_SYSTEM_CONTROL[7:2]: d.rdata = q.system_control;
        ADDR_MODE[7:2]: d.rdata = q.mode;
        default: begin
          d.rdata = 8'h00;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (!q.rvalid && !q.arready && arvalid) begin
      d.arready = 1'b1;
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (rd_host_port_control_status && q.host_port_control_status[BIT_RD_DONE]) begin
      d.rd_arm = 1'b1;
    end
    if (rd_host_port_control_status && q.host_port_control_status[BIT_WR_DONE]) begin
      d.wr_arm = 1'b1;
    end

    // Standby holds the slave enable off for as long as it lasts
    if (!q.stby_sync[1]) begin
      d.system_control[BIT_SLAVE_EN] = 1'b0;
    end

    d.rd_irq = d.host_port_control_status[BIT_RD_DONE] & d.host_port_control_status[BIT_RD_IRQ_EN];
    d.wr_irq = d.host_port_control_status[BIT_WR_DONE] & d.host_port_control_status[BIT_WR_IRQ_EN];

    d.ready_pin_o = 1'b0;
    d.ready_pin_oe = 1'b0;
    d.wait_pin_o = 1'b1;
    d.wait_pin_oe = 1'b0;
    if (slave_mode_en) begin
      if (expanded) begin
        d.ready_pin_o = addr_strobe_out;
        d.ready_pin_oe = 1'b1;
      end else if (rd_ack || wr_ack || xm == XM_HS) begin
        // Open drain: high is released, never driven
        d.ready_pin_oe = ~q.ext_host_ready;
      end
      if (q.host_port_control_status[BIT_WAIT_EN]) begin
        d.wait_pin_o = q.host_wait_req_n;
        d.wait_pin_oe = 1'b1;
      end else if (expanded) begin
        d.wait_pin_oe = 1'b1;
        if (xm == XM_HS || rd_ack || wr_ack) begin
          d.wait_pin_o = q.ext_host_ready;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.system_control <= SYSTEM_CONTROL_RESET;
      q.host_wait_req_n <= 1'b1;
      q.oe_sync <= 3'h7;
      q.we_sync <= 3'h7;
      q.stby_sync <= 2'h3;
      q.wait_pin_o <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rresp = q.rresp;
  assign rdata = {24'h000000, q.rdata};
  assign ready_pin_o = q.ready_pin_o;
  assign ready_pin_oe = q.ready_pin_oe;
  assign wait_pin_o = q.wait_pin_o;
  assign wait_pin_oe = q.wait_pin_oe;
  assign read_done_irq = q.rd_irq;
  assign write_done_irq = q.wr_irq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_rd_irq;
    read_done_irq == (q.host_port_control_status[BIT_RD_DONE] & q.host_port_control_status[BIT_RD_IRQ_EN]);
  endproperty
  a_rd_irq: assert property (p_rd_irq)
    else $error("read-done interrupt mismatch");

  property p_wr_irq;
    write_done_irq == (q.host_port_control_status[BIT_WR_DONE] & q.host_port_control_status[BIT_WR_IRQ_EN]);
  endproperty
  a_wr_irq: assert property (p_wr_irq)
    else $error("write-done interrupt mismatch");

  property p_hs_wait;
    hs_wait_cond [*8] |=> q.host_wait_req_n;
  endproperty
  a_hs_wait: assert property (p_hs_wait)
    else $error("handshake wait not raised after eight clocks");

  property p_keep_unarmed;
    (xm == XM_BOUND) && q.host_port_control_status[BIT_RD_DONE] && !q.rd_arm
      |=> q.host_port_control_status[BIT_RD_DONE];
  endproperty
  a_keep_unarmed: assert property (p_keep_unarmed)
    else $error("read-done cleared without prior read");

  property p_one_keeps;
    wr_host_port_control_status && wdata[BIT_WR_DONE] && q.host_port_control_status[BIT_WR_DONE]
      |=> q.host_port_control_status[BIT_WR_DONE];
  endproperty
  a_one_keeps: assert property (p_one_keeps)
    else $error("writing one changed write-done");

  property p_direct_set;
    (xm == XM_DIRECT) && host_rd_read_lo |=> q.host_port_control_status[BIT_RD_DONE];
  endproperty
  a_direct_set: assert property (p_direct_set)
    else $error("direct read did not set read-done");

  property p_hs_we_rise;
    (xm == XM_HS) && we_rise |=> q.host_port_control_status[BIT_WR_DONE];
  endproperty
  a_hs_we_rise: assert property (p_hs_we_rise)
    else $error("strobe rise did not set write-done");

  property p_open_drain;
    !$past(expanded) |-> !(ready_pin_oe && ready_pin_o);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("single-chip ready pin driven high");

  property p_as_out;
    expanded && slave_mode_en && $stable(q.system_control) && $stable(q.mode)
      |=> ready_pin_oe && (ready_pin_o == $past(addr_strobe_out));
  endproperty
  a_as_out: assert property (p_as_out)
    else $error("ready pin not carrying address strobe");

  property p_standby;
    !q.stby_sync[1] |=> !slave_mode_en;
  endproperty
  a_standby: assert property (p_standby)
    else $error("slave enable survived standby");

  property p_hs_ready_low;
    (xm == XM_HS) && oe_hi && !we_hi |=> !q.ext_host_ready;
  endproperty
  a_hs_ready_low: assert property (p_hs_ready_low)
    else $error("handshake ready not low");

  property p_bresp_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped before taken");

  property p_cov_hs_wait;
    (xm == XM_HS) && $rose(q.host_wait_req_n);
  endproperty
  c_hs_wait: cover property (p_cov_hs_wait);

  property p_cov_bound_clear;
    (xm == XM_BOUND) && sw_clr_rd;
  endproperty
  c_bound_clear: cover property (p_cov_bound_clear);

  property p_cov_slverr;
    bvalid && bresp == RESP_SLVERR;
  endproperty
  c_slverr: cover property (p_cov_slverr);
endmodule
`default_nettype wire
